// >>> design/cst_pkg.sv
package cst_pkg;

  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_CONTROL = 8'hA0;
  localparam logic [7:0] IDX_CONFIG = 8'hA1;
  localparam logic [7:0] IDX_ANALOG = 8'hA2;
  localparam logic [7:0] IDX_COUNT_LOW = 8'hA4;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'hA5;
  localparam logic [7:0] IDX_STATUS = 8'hA6;
  localparam logic [7:0] IDX_TIMER_DATA = 8'hA7;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ==========================================================
  // reset values and widths
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CNT_W = 8;
  localparam int SIX_W = 6;
  localparam int TMR_W = 6;
  localparam int DIV_W = 3;

  // ==========================================================
  // field positions
  localparam int ANA_PIN_DRIVE_BIT = 2;
  localparam int ANA_RELAX_EN_BIT = 0;

  // ==========================================================
  // selected event inputs
  localparam logic [2:0] SEL_COMP0 = 3'h0;
  localparam logic [2:0] SEL_LOW_SPEED = 3'h1;
  localparam logic [2:0] SEL_COMP1 = 3'h2;
  localparam logic [2:0] SEL_TIMER_TC = 3'h3;
  localparam logic [2:0] SEL_EXT_TIMER = 3'h4;
  localparam logic [2:0] SEL_TIMER_IRQ = 3'h5;
  localparam logic [2:0] SEL_ANALOG_BUS = 3'h6;

  // ==========================================================
  // pin output selections
  localparam logic [1:0] OUT_INPUT = 2'h0;
  localparam logic [1:0] OUT_INT = 2'h1;
  localparam logic [1:0] OUT_LOW_CARRY = 2'h2;

  // ==========================================================
  // counting modes and counter phases
  typedef enum logic [1:0] {
    CST_MODE_STOP_EVENT = 2'h0,
    CST_MODE_PULSE_WIDTH = 2'h1,
    CST_MODE_PERIOD = 2'h2,
    CST_MODE_CONTINUOUS = 2'h3
  } cst_mode_t;

  typedef enum {CST_PH_OFF, CST_PH_ARM, CST_PH_RUN, CST_PH_HOLD} cst_phase_t;
  typedef enum {CST_TM_IDLE, CST_TM_COUNT, CST_TM_DONE} cst_timer_t;

  // ==========================================================
  // register layouts
  typedef struct packed {
    logic [1:0] pin_output_select;
    logic switch_clock_select;
    logic counter_source_select;
    logic sigma_delta_enable;
    logic [1:0] mode;
    logic enable;
  } cst_control_t;

  typedef struct packed {
    logic chain;
    logic [1:0] count_clock_divider;
    logic high_on_relax;
    logic input_polarity_flip;
    logic [2:0] event_input_select;
  } cst_config_t;

  typedef struct packed {
    logic input_rise;
    logic low_carry;
    logic high_carry;
    logic timer_tc;
    logic [3:0] mask;
  } cst_status_t;

  // ==========================================================
  // asynchronous pins from the analog front end and clocks
  typedef struct packed {
    logic comp0;
    logic comp1;
    logic analog_bus;
    logic relax_osc_clock;
    logic low_speed_osc;
    logic pseudo_random_seq;
    logic ext_timer;
    logic timer_irq;
  } cst_pins_t;

endpackage : cst_pkg

// >>> design/cst_counter_timer.sv
`timescale 1ns/1ps
`default_nettype none

module cst_counter_timer
  import cst_pkg::*;
#(
  parameter int PRESCALE_DIV = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cst_pkg::ADDR_W-1:0] paddr,
  input wire logic [cst_pkg::DATA_W-1:0] pwdata,
  output logic [cst_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog front end and oscillator pins
  input wire cst_pkg::cst_pins_t pins,
  // outputs
  output logic pin_out,
  output logic switch_clock,
  output logic timer_tc_out,
  output logic [7:0] sense_analog_control_out
);
  import cst_pkg::*;

  // ==========================================================
  // registers and state
  cst_control_t sense_counter_control;
  cst_config_t sense_counter_config;
  logic [7:0] sense_analog_control;
  logic [TMR_W-1:0] timer_data;
  cst_status_t status;
  logic [CNT_W-1:0] count_low;
  logic [CNT_W-1:0] count_high;
  logic [SIX_W-1:0] count_six;
  cst_phase_t phase;
  cst_timer_t tm_state;
  logic [TMR_W-1:0] tm_count;
  logic tm_tc;
  logic tm_tc_d;
  logic tm_en_s1;
  logic tm_en_s2;
  cst_pins_t pin_s1;
  cst_pins_t pin_s2;
  cst_pins_t pin_d;
  logic [$clog2(PRESCALE_DIV+1)-1:0] pre_count;
  logic pre_tick;
  logic pre_level;
  logic [DIV_W-1:0] div_count;
  logic sel_d;

  // ==========================================================
  // helpers
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {2'b00, idx, 2'b00});
  endfunction : reg_hit

  function automatic logic div_hit(input logic [DIV_W-1:0] cnt, input logic [1:0] sel);
    logic [DIV_W-1:0] mask;
    mask = DIV_W'((4'h1 << sel) - 4'h1);
    div_hit = ((cnt & mask) == mask);
  endfunction : div_hit

  // ==========================================================
  // bus decode
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign mapped = reg_hit(paddr, IDX_CONTROL) | reg_hit(paddr, IDX_CONFIG)
    | reg_hit(paddr, IDX_ANALOG) | reg_hit(paddr, IDX_COUNT_LOW)
    | reg_hit(paddr, IDX_COUNT_HIGH) | reg_hit(paddr, IDX_STATUS)
    | reg_hit(paddr, IDX_TIMER_DATA);

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d <= '0;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  logic relax_tick;
  logic slow_tick;
  assign relax_tick = pin_s2.relax_osc_clock & ~pin_d.relax_osc_clock;
  assign slow_tick = pin_s2.low_speed_osc & ~pin_d.low_speed_osc;

  // ==========================================================
  // free-running prescaler for the prescaled main osc
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_count <= '0;
      pre_tick <= 1'b0;
      pre_level <= 1'b0;
    end else begin
      pre_tick <= (pre_count == $bits(pre_count)'(PRESCALE_DIV - 1));
      if (pre_count == $bits(pre_count)'(PRESCALE_DIV - 1)) begin
        pre_count <= '0;
        pre_level <= ~pre_level;
      end else begin
        pre_count <= pre_count + 1'b1;
      end
    end
  end

  // ==========================================================
  // count clock divider
  logic src_tick;
  logic count_tick;
  assign src_tick = sense_counter_control.counter_source_select ? pre_tick : 1'b1;
  assign count_tick = src_tick
    & div_hit(div_count, sense_counter_config.count_clock_divider);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= '0;
    end else if (src_tick) begin
      div_count <= div_count + 1'b1;
    end
  end

  // ==========================================================
  // event input selection
  logic sel_raw;
  logic sel_in;
  always_comb begin
    case (sense_counter_config.event_input_select)
      SEL_COMP0: sel_raw = pin_s2.comp0;
      SEL_LOW_SPEED: sel_raw = pin_s2.low_speed_osc;
      SEL_COMP1: sel_raw = pin_s2.comp1;
      SEL_TIMER_TC: sel_raw = tm_tc;
      SEL_EXT_TIMER: sel_raw = pin_s2.ext_timer;
      SEL_TIMER_IRQ: sel_raw = pin_s2.timer_irq;
      SEL_ANALOG_BUS: sel_raw = pin_s2.analog_bus;
      default: sel_raw = 1'b0;
    endcase
  end
  assign sel_in = sel_raw ^ sense_counter_config.input_polarity_flip;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_d <= 1'b0;
    end else begin
      sel_d <= sel_in;
    end
  end

  logic sel_rise;
  logic sel_fall;
  assign sel_rise = sel_in & ~sel_d;
  assign sel_fall = ~sel_in & sel_d;

  // ==========================================================
  // counter clocking and gating
  logic enabled;
  logic relax_mode;
  logic method_one;
  logic method_two;
  logic chain;
  logic gate;
  logic tick_low;
  logic tick_high;
  logic tick_six;
  logic low_carry;
  logic high_carry;
  logic live;
  logic cs_int;
  logic stop;
  cst_mode_t mode;

  assign enabled = sense_counter_control.enable;
  assign mode = cst_mode_t'(sense_counter_control.mode);
  assign chain = sense_counter_config.chain;
  assign relax_mode = sense_analog_control[ANA_RELAX_EN_BIT];
  assign method_one = relax_mode & ~chain & sense_counter_config.high_on_relax;
  assign method_two = relax_mode & chain;
  assign gate = (phase == CST_PH_RUN)
    & (~sense_counter_control.sigma_delta_enable
       | (pin_s2.comp0 & (tm_state == CST_TM_COUNT)));
  assign tick_low = gate & count_tick;
  assign tick_high = gate & (chain ? (count_tick & (count_low == '1))
    : (method_one ? relax_tick : count_tick));
  assign tick_six = gate & method_two & relax_tick;
  assign low_carry = tick_low & (count_low == '1);
  assign high_carry = tick_high & (count_high == '1);
  assign live = (phase == CST_PH_ARM) | (phase == CST_PH_RUN);
  assign cs_int = |({status.input_rise, status.low_carry, status.high_carry, status.timer_tc}
    & status.mask);

  always_comb begin
    stop = 1'b0;
    if (method_one) begin
      stop = low_carry;
    end else if (method_two) begin
      stop = tick_six & (count_six == '1);
    end else begin
      case (mode)
        CST_MODE_STOP_EVENT: stop = cs_int;
        CST_MODE_PULSE_WIDTH: stop = sel_fall;
        CST_MODE_PERIOD: stop = sel_rise;
        default: stop = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // counter phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= CST_PH_OFF;
    end else if (!enabled) begin
      phase <= CST_PH_OFF;
    end else begin
      case (phase)
        CST_PH_OFF: begin
          if (!relax_mode && (mode == CST_MODE_PULSE_WIDTH || mode == CST_MODE_PERIOD)) begin
            phase <= CST_PH_ARM;
          end else begin
            phase <= CST_PH_RUN;
          end
        end
        CST_PH_ARM: begin
          if (sel_rise) begin
            phase <= CST_PH_RUN;
          end
        end
        CST_PH_RUN: begin
          if (stop) begin
            phase <= CST_PH_HOLD;
          end
        end
        CST_PH_HOLD: phase <= CST_PH_HOLD;
        default: phase <= CST_PH_OFF;
      endcase
    end
  end

  // ==========================================================
  // counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low <= '0;
      count_high <= '0;
      count_six <= '0;
    end else if (!enabled) begin
      count_low <= '0;
      count_high <= '0;
      count_six <= '0;
    end else if (!stop) begin
      if (tick_low) begin
        count_low <= count_low + 1'b1;
      end
      if (tick_high) begin
        count_high <= count_high + 1'b1;
      end
      if (tick_six) begin
        count_six <= count_six + 1'b1;
      end
    end
  end

  // ==========================================================
  // programmable timer
  logic tm_tick;
  assign tm_tick = sense_counter_control.sigma_delta_enable ? pre_tick
    : (sense_analog_control[ANA_PIN_DRIVE_BIT] ? count_tick : slow_tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tm_en_s1 <= 1'b0;
      tm_en_s2 <= 1'b0;
    end else if (tm_tick) begin
      tm_en_s1 <= enabled;
      tm_en_s2 <= tm_en_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tm_state <= CST_TM_IDLE;
      tm_count <= '0;
      tm_tc <= 1'b0;
    end else if (tm_tick) begin
      if (!tm_en_s2) begin
        tm_state <= CST_TM_IDLE;
        tm_count <= '0;
        tm_tc <= 1'b0;
      end else begin
        case (tm_state)
          CST_TM_IDLE: begin
            tm_count <= timer_data;
            tm_tc <= (timer_data == '0);
            tm_state <= (timer_data == '0) ? CST_TM_DONE : CST_TM_COUNT;
          end
          CST_TM_COUNT: begin
            tm_count <= tm_count - 1'b1;
            tm_tc <= (tm_count == TMR_W'(1));
            if (tm_count == TMR_W'(1)) begin
              tm_state <= CST_TM_DONE;
            end
          end
          CST_TM_DONE: tm_tc <= 1'b0;
          default: tm_state <= CST_TM_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tm_tc_d <= 1'b0;
    end else begin
      tm_tc_d <= tm_tc;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_counter_control <= cst_control_t'(REG_RESET);
      sense_counter_config <= cst_config_t'(REG_RESET);
      sense_analog_control <= REG_RESET;
      timer_data <= TMR_W'(REG_RESET);
    end else if (wr) begin
      if (reg_hit(paddr, IDX_CONTROL)) begin
        sense_counter_control <= cst_control_t'(pwdata[7:0]);
      end
      if (reg_hit(paddr, IDX_CONFIG)) begin
        sense_counter_config <= cst_config_t'(pwdata[7:0]);
      end
      if (reg_hit(paddr, IDX_ANALOG)) begin
        sense_analog_control <= pwdata[7:0];
      end
      if (reg_hit(paddr, IDX_TIMER_DATA)) begin
        timer_data <= pwdata[TMR_W-1:0];
      end
    end
  end

  // ==========================================================
  // status flags: set wins over a zero write
  logic st_wr;
  assign st_wr = wr & reg_hit(paddr, IDX_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= cst_status_t'(REG_RESET);
    end else begin
      if (st_wr) begin
        status.mask <= pwdata[3:0];
      end
      if (!enabled) begin
        status.input_rise <= 1'b0;
        status.low_carry <= 1'b0;
        status.high_carry <= 1'b0;
        status.timer_tc <= 1'b0;
      end else begin
        status.input_rise <= (live & sel_rise)
          | (status.input_rise & ~(st_wr & ~pwdata[7]));
        status.low_carry <= (live & low_carry)
          | (status.low_carry & ~(st_wr & ~pwdata[6]));
        status.high_carry <= (live & high_carry)
          | (status.high_carry & ~(st_wr & ~pwdata[5]));
        status.timer_tc <= (live & tm_tc & ~tm_tc_d)
          | (status.timer_tc & ~(st_wr & ~pwdata[4]));
      end
    end
  end

  // ==========================================================
  // apb answer: pready one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= '0;
      if (setup && !pwrite) begin
        if (reg_hit(paddr, IDX_CONTROL)) begin
          prdata <= DATA_W'(sense_counter_control);
        end else if (reg_hit(paddr, IDX_CONFIG)) begin
          prdata <= DATA_W'(sense_counter_config);
        end else if (reg_hit(paddr, IDX_ANALOG)) begin
          prdata <= DATA_W'(sense_analog_control);
        end else if (reg_hit(paddr, IDX_COUNT_LOW)) begin
          prdata <= DATA_W'(count_low);
        end else if (reg_hit(paddr, IDX_COUNT_HIGH)) begin
          prdata <= DATA_W'(count_high);
        end else if (reg_hit(paddr, IDX_STATUS)) begin
          prdata <= DATA_W'(status);
        end else if (reg_hit(paddr, IDX_TIMER_DATA)) begin
          prdata <= DATA_W'(timer_data);
        end
      end
    end
  end

  // ==========================================================
  // pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      switch_clock <= 1'b0;
      timer_tc_out <= 1'b0;
      sense_analog_control_out <= REG_RESET;
    end else begin
      case (sense_counter_control.pin_output_select)
        OUT_INPUT: pin_out <= sel_in;
        OUT_INT: pin_out <= cs_int;
        OUT_LOW_CARRY: pin_out <= low_carry;
        default: pin_out <= high_carry;
      endcase
      switch_clock <= sense_counter_control.switch_clock_select
        ? pin_s2.pseudo_random_seq : pre_level;
      timer_tc_out <= tm_tc;
      sense_analog_control_out <= sense_analog_control;
    end
  end

endmodule : cst_counter_timer

`default_nettype wire

// >>> verif/cst_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cst_chk
  import cst_pkg::*;
(
  // bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cst_pkg::ADDR_W-1:0] paddr,
  input wire logic [cst_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // outputs
  input wire logic [7:0] sense_analog_control_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ========================
  // bus answer
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("read data outside answer");
  a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_err_unmapped: assert property (pready && paddr == 12'h28C |-> pslverr)
    else $error("unmapped address accepted");
  a_err_mapped: assert property (pready && paddr == 12'h280 |-> !pslverr)
    else $error("mapped address refused");
  a_analog_hold: assert property ((!(pready && pwrite)) [*2] |=>
    $stable(sense_analog_control_out)) else $error("analog copy moved without write");
endmodule : cst_chk

bind cst_counter_timer cst_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .sense_analog_control_out);

`default_nettype wire

// >>> verif/tb_cst_counter_timer.sv
`timescale 1ns/1ps
`default_nettype none

module tb_cst_counter_timer;
  import cst_pkg::*;
  localparam logic [7:0] WM [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h3F};
  logic pclk;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic pready, pslverr, pin_out, switch_clock, timer_tc_out, er;
  logic [7:0] sense_analog_control_out;
  logic [7:0] m [8];
  cst_pins_t pins = '0;
  logic slow_on = 0;
  logic slow_osc = 0;
  logic relax_osc = 0;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0;

  cst_counter_timer #(.PRESCALE_DIV(2)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pins({pins[7:5], relax_osc, slow_osc, pins[2:0]}), .pin_out, .switch_clock,
    .timer_tc_out, .sense_analog_control_out);

  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end

  // ========================
  // slow clock and timeout
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (slow_on && cyc % 8 == 0) slow_osc <= ~slow_osc;
    if (cyc % 4 == 0) relax_osc <= ~relax_osc;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ========================
  // tasks
  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask : cy

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1, idx, d);
    m[idx - 8'hA0] = d & WM[idx - 8'hA0];
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(0, idx, 0);
    chk({er, rd}, {25'h0, exp});
  endtask : rdc

  task automatic gap(output int n);
    int k;
    k = 0;
    while (pin_out !== 1'b1 && k < 3000) begin
      @(negedge pclk);
      k++;
    end
    t0 = cyc;
    while (pin_out === 1'b1) @(negedge pclk);
    while (pin_out !== 1'b1 && cyc - t0 < 3000) @(negedge pclk);
    n = cyc - t0;
  endtask : gap

  task automatic tcw(input int lim, output int w);
    int k;
    k = 0;
    w = 0;
    while (timer_tc_out !== 1'b1 && k < lim) begin
      @(negedge pclk);
      k++;
    end
    if (k < lim) begin
      t0 = cyc;
      while (timer_tc_out === 1'b1) @(negedge pclk);
      w = cyc - t0;
    end
  endtask : tcw

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // ========================
  // main sequence
  initial begin
    int n;
    void'($urandom(32'h31ea));
    for (int i = 0; i < 8; i++) m[i] = 0;
    cy(12);
    presetn <= 1;
    for (int i = 0; i < 8; i++) if (i != 3) rdc(8'hA0 + i, 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) wr(8'hA0 + i, 8'($urandom) & (i == 7 ? 8'h3F : 8'hFE));
    for (int i = 0; i < 8; i++) if (i != 3) rdc(8'hA0 + i, m[i]);
    chk(sense_analog_control_out, m[2]);
    apb(1, 8'hA3, 8'hFF);
    chk(er, 1);
    apb(0, 8'hA3, 0);
    chk({er, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) wr(8'hA0 + i, 0);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      wr(8'hA1, 8'(c << 5));
      wr(8'hA0, 8'h87);
      gap(n);
      chk(n, 256 << c);
      apb(0, 8'hA6, 0);
      chk(rd & 8'h40, 8'h40);
      wr(8'hA0, 8'h86);
      rdc(8'hA4, 0);
      rdc(8'hA6, 0);
    end
    $display("test continuous done");
    wr(8'hA1, 8'h80);
    wr(8'hA6, 8'h08);
    wr(8'hA0, 8'h01);
    cy(300);
    pins.comp0 <= 1;
    cy(20);
    apb(0, 8'hA4, 0);
    n = rd;
    chk(n >= 8'h2C && n <= 8'h30, 1);
    cy(10);
    rdc(8'hA4, n);
    rdc(8'hA5, 1);
    apb(0, 8'hA6, 0);
    chk(rd & 8'h8F, 8'h88);
    chk(pin_out, 1);
    wr(8'hA0, 0);
    rdc(8'hA4, 0);
    wr(8'hA1, 8'h07);
    cy(5);
    chk(pin_out, 0);
    wr(8'hA6, 0);
    $display("test stop on event done");
    for (int md = 1; md < 3; md++) begin
      pins.comp0 <= 0;
      wr(8'hA1, 0);
      wr(8'hA0, 8'(md << 1) | 8'h01);
      cy(10);
      pins.comp0 <= 1;
      cy(40);
      pins.comp0 <= 0;
      cy(20);
      pins.comp0 <= 1;
      cy(10);
      apb(0, 8'hA4, 0);
      n = rd - 20 * md;
      chk(n >= 19 && n <= 21, 1);
      wr(8'hA0, 8'(md << 1));
    end
    $display("test edge modes done");
    slow_on <= 1;
    wr(8'hA7, 8'h03);
    for (int r = 0; r < 2; r++) begin
      wr(8'hA0, 8'h01);
      tcw(1000, n);
      chk(n, 16);
      tcw(300, n);
      chk(n, 0);
      wr(8'hA0, 0);
      cy(50);
    end
    $display("test timer done");
    wr(8'hA0, 8'h20);
    for (int v = 0; v < 2; v++) begin
      pins.pseudo_random_seq <= v[0];
      cy(5);
      chk(switch_clock, v[0]);
    end
    $display("test switch clock done");
    wr(8'hA2, 8'h01);
    wr(8'hA1, 8'h10);
    wr(8'hA0, 8'h11);
    cy(600);
    rdc(8'hA4, 8'hFF);
    apb(0, 8'hA5, 0);
    chk(rd >= 62 && rd <= 66, 1);
    wr(8'hA0, 8'h10);
    for (int i = 0; i < 3; i++) wr(8'hA0 + i, 0);
    $display("test relax method done");
    print_verdict();
  end
endmodule : tb_cst_counter_timer

`default_nettype wire
